// ===== hw/efch_regs.sv
// Purpose: configuration header of the error-reporting function, APB slave
// Assumes: single clock pclk, async active-low presetn, inputs synchronous
// Notes:   ready in the first access cycle; unmapped addresses answer pslverr
//
// Overview of operation
// - set status bit 14 when message sent
// - writing one clears the signaled bit
// - other status bits read zero, reset 0000h
// - revision read-only, equals primary function revision
// - sub-class reads 00h always
// - base class reads FFh, undefined class
// - latency byte unimplemented, reads 00h, ignores writes
// - header byte reads 00h, no side effects
// - board vendor tag writable once, resets 0000h
// - board product tag writable once, resets 0000h
// - enable bit 8 clear blocks messages

`timescale 1ns/1ps

module efch_regs
#(
	parameter int unsigned ADDR_W       = 8,
	// arbitrary value, stands for the primary function's revision
	parameter logic [7:0]  REVISION_VAL = 8'h3C
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              error_event,
	output logic                   serr_msg,
	output logic                   system_error_signaled,
	output logic                   irq
);

	// address width the decode can serve
	if (ADDR_W < 8 || ADDR_W > 32)
	begin : g_addr_w_check
		$error("efch_regs: ADDR_W must lie between 8 and 32");
	end

	efch_pkg::efch_state_t st_r;
	efch_pkg::efch_state_t st_nxt;

	efch_pkg::efch_fwr_t           vendor_wr;
	efch_pkg::efch_fwr_t           product_wr;
	logic [efch_pkg::SUBSYS_W-1:0] vendor_val;
	logic [efch_pkg::SUBSYS_W-1:0] product_val;

	logic [ADDR_W-1:0] word_idx;
	logic              aligned;
	logic              setup;
	logic              take;
	logic              wr_take;
	logic [31:0]       bit_mask;
	logic [31:0]       wr_ones;
	logic              send_msg;

	// match a register index against the word address
	function automatic logic idx_hit(input logic [ADDR_W-1:0] idx, input logic [7:0] reg_idx);
		idx_hit = (idx == ADDR_W'(reg_idx));
	endfunction

	// known register at this index
	function automatic logic idx_mapped(input logic [ADDR_W-1:0] idx);
		idx_mapped = idx_hit(idx, efch_pkg::IDX_COMMAND)
			|| idx_hit(idx, efch_pkg::IDX_STATUS)
			|| idx_hit(idx, efch_pkg::IDX_REVISION)
			|| idx_hit(idx, efch_pkg::IDX_SUBCLASS)
			|| idx_hit(idx, efch_pkg::IDX_BASE_CLASS)
			|| idx_hit(idx, efch_pkg::IDX_LATENCY)
			|| idx_hit(idx, efch_pkg::IDX_HEADER)
			|| idx_hit(idx, efch_pkg::IDX_BOARD_VENDOR)
			|| idx_hit(idx, efch_pkg::IDX_BOARD_PROD)
			|| idx_hit(idx, efch_pkg::IDX_IRQ_STATUS)
			|| idx_hit(idx, efch_pkg::IDX_IRQ_MASK);
	endfunction

	// bus decode
	assign word_idx = paddr >> 2;
	assign aligned  = (paddr[1:0] == 2'h0);
	assign setup    = psel && !penable;
	assign take     = psel && penable && st_r.pready;
	assign wr_take  = take && pwrite && !st_r.pslverr;
	assign bit_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wr_ones  = pwdata & bit_mask;

	// message goes out only with the global enable set
	assign send_msg = error_event && st_r.serr_en;

	// write-once subsystem fields
	always_comb
	begin
		vendor_wr.en    = wr_take && idx_hit(word_idx, efch_pkg::IDX_BOARD_VENDOR);
		vendor_wr.mask  = bit_mask[efch_pkg::SUBSYS_W-1:0];
		vendor_wr.data  = pwdata[efch_pkg::SUBSYS_W-1:0];
		product_wr.en   = wr_take && idx_hit(word_idx, efch_pkg::IDX_BOARD_PROD);
		product_wr.mask = bit_mask[efch_pkg::SUBSYS_W-1:0];
		product_wr.data = pwdata[efch_pkg::SUBSYS_W-1:0];
	end

	efch_w1o_field u_vendor
	(
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (vendor_wr),
		.value   (vendor_val),
		.locked  ()
	);

	efch_w1o_field u_product
	(
		.pclk    (pclk),
		.presetn (presetn),
		.wr      (product_wr),
		.value   (product_val),
		.locked  ()
	);

	// read data for the word under decode
	function automatic logic [31:0] read_word(input efch_pkg::efch_state_t s,
		input logic [ADDR_W-1:0] idx,
		input logic [15:0] vend,
		input logic [15:0] prod);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (idx_hit(idx, efch_pkg::IDX_COMMAND))
			d[efch_pkg::SERR_EN_BIT] = s.serr_en;
		else if (idx_hit(idx, efch_pkg::IDX_STATUS))
			d[efch_pkg::SIGNALED_BIT] = s.sys_err_sig;
		else if (idx_hit(idx, efch_pkg::IDX_REVISION))
			d[7:0] = REVISION_VAL;
		else if (idx_hit(idx, efch_pkg::IDX_SUBCLASS))
			d[7:0] = efch_pkg::SUBCLASS_VAL;
		else if (idx_hit(idx, efch_pkg::IDX_BASE_CLASS))
			d[7:0] = efch_pkg::BASE_CLASS_VAL;
		else if (idx_hit(idx, efch_pkg::IDX_LATENCY))
			d[7:0] = efch_pkg::LATENCY_VAL;
		else if (idx_hit(idx, efch_pkg::IDX_HEADER))
			d[7:0] = efch_pkg::HEADER_VAL;
		else if (idx_hit(idx, efch_pkg::IDX_BOARD_VENDOR))
			d[15:0] = vend;
		else if (idx_hit(idx, efch_pkg::IDX_BOARD_PROD))
			d[15:0] = prod;
		else if (idx_hit(idx, efch_pkg::IDX_IRQ_STATUS))
			d[efch_pkg::IRQ_W-1:0] = s.irq_stat;
		else if (idx_hit(idx, efch_pkg::IDX_IRQ_MASK))
			d[efch_pkg::IRQ_W-1:0] = s.irq_mask;
		else
			d = 32'h0000_0000;
		return d;
	endfunction

	always_comb
	begin
		st_nxt = st_r;

		// apb handshake: ready in the first access cycle
		st_nxt.pready = setup;
		if (setup)
		begin
			st_nxt.pslverr = !(aligned && idx_mapped(word_idx));
			if (!pwrite && aligned && idx_mapped(word_idx))
				st_nxt.prdata = read_word(st_r, word_idx, vendor_val, product_val);
			else
				st_nxt.prdata = 32'h0000_0000;
		end
		else if (take)
		begin
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata  = 32'h0000_0000;
		end

		// command register, only the global enable bit lives
		if (wr_take && idx_hit(word_idx, efch_pkg::IDX_COMMAND)
			&& pstrb[efch_pkg::SERR_EN_BIT / 8])
			st_nxt.serr_en = pwdata[efch_pkg::SERR_EN_BIT];

		// signaled bit: clear by one, set wins and holds
		if (wr_take && idx_hit(word_idx, efch_pkg::IDX_STATUS)
			&& wr_ones[efch_pkg::SIGNALED_BIT])
			st_nxt.sys_err_sig = 1'b0;
		if (send_msg)
			st_nxt.sys_err_sig = 1'b1;

		// message pulse out over the hub link
		st_nxt.serr_msg = send_msg;

		// interrupt status: clear by one, set wins
		if (wr_take && idx_hit(word_idx, efch_pkg::IDX_IRQ_STATUS))
			st_nxt.irq_stat = st_r.irq_stat & ~wr_ones[efch_pkg::IRQ_W-1:0];
		if (send_msg)
			st_nxt.irq_stat[efch_pkg::IRQ_MSG_BIT] = 1'b1;
		if (error_event && !st_r.serr_en)
			st_nxt.irq_stat[efch_pkg::IRQ_SUPP_BIT] = 1'b1;

		// interrupt mask
		if (wr_take && idx_hit(word_idx, efch_pkg::IDX_IRQ_MASK) && pstrb[0])
			st_nxt.irq_mask = pwdata[efch_pkg::IRQ_W-1:0];

		// level interrupt from next-state values
		st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= efch_pkg::STATE_RST;
		else
			st_r <= st_nxt;
	end

	assign pready                = st_r.pready;
	assign prdata                = st_r.prdata;
	assign pslverr               = st_r.pslverr;
	assign serr_msg              = st_r.serr_msg;
	assign system_error_signaled = st_r.sys_err_sig;
	assign irq                   = st_r.irq;

endmodule

// ===== common/efch_pkg.sv
// Purpose: constants and types for the error function configuration header
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   byte address of each register is four times its index

package efch_pkg;

	// register indices; byte address is index * 4
	localparam logic [7:0] IDX_COMMAND      = 8'h04;
	localparam logic [7:0] IDX_STATUS       = 8'h06;
	localparam logic [7:0] IDX_REVISION     = 8'h08;
	localparam logic [7:0] IDX_SUBCLASS     = 8'h0A;
	localparam logic [7:0] IDX_BASE_CLASS   = 8'h0B;
	localparam logic [7:0] IDX_LATENCY      = 8'h0D;
	localparam logic [7:0] IDX_HEADER       = 8'h0E;
	localparam logic [7:0] IDX_BOARD_VENDOR = 8'h2C;
	localparam logic [7:0] IDX_BOARD_PROD   = 8'h2E;
	localparam logic [7:0] IDX_IRQ_STATUS   = 8'h30;
	localparam logic [7:0] IDX_IRQ_MASK     = 8'h31;

	// field positions
	localparam int unsigned SIGNALED_BIT    = 14;
	localparam int unsigned SERR_EN_BIT     = 8;
	localparam int unsigned IRQ_MSG_BIT     = 0;
	localparam int unsigned IRQ_SUPP_BIT    = 1;
	localparam int unsigned IRQ_W           = 2;
	localparam int unsigned SUBSYS_W        = 16;

	// values after reset and fixed read values
	localparam logic [15:0] STATUS_RST      = 16'h0000;
	localparam logic [15:0] COMMAND_RST     = 16'h0000;
	localparam logic [7:0]  SUBCLASS_VAL    = 8'h00;
	localparam logic [7:0]  BASE_CLASS_VAL  = 8'hFF;
	localparam logic [7:0]  LATENCY_VAL     = 8'h00;
	localparam logic [7:0]  HEADER_VAL      = 8'h00;
	localparam logic [15:0] SUBSYS_RST      = 16'h0000;
	localparam logic [1:0]  IRQ_RST         = 2'h0;
	localparam logic [31:0] PRDATA_RST      = 32'h0000_0000;

	// write-once field state
	typedef struct packed
	{
		logic [SUBSYS_W-1:0] value;
		logic                locked;
	} efch_w1o_t;

	// write request as seen by a field
	typedef struct packed
	{
		logic                en;
		logic [SUBSYS_W-1:0] mask;
		logic [SUBSYS_W-1:0] data;
	} efch_fwr_t;

	// main block state
	typedef struct packed
	{
		logic             serr_en;
		logic             sys_err_sig;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic             serr_msg;
		logic             irq;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
	} efch_state_t;

	localparam efch_w1o_t W1O_RST = '{value: SUBSYS_RST, locked: 1'b0};

	localparam efch_state_t STATE_RST = '{
		serr_en:  1'b0,
		sys_err_sig: 1'b0,
		irq_stat: IRQ_RST,
		irq_mask: IRQ_RST,
		serr_msg: 1'b0,
		irq:      1'b0,
		pready:   1'b0,
		pslverr:  1'b0,
		prdata:   PRDATA_RST
	};

endpackage

// ===== hw/efch_w1o_field.sv
// Purpose: write-once field, takes one write then reads only
// Assumes: wr.en is a one-cycle pulse at the taking edge
// Notes:   any write with a non-zero byte mask uses up the single write

`timescale 1ns/1ps

module efch_w1o_field
(
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	input  wire efch_pkg::efch_fwr_t               wr,
	output logic [efch_pkg::SUBSYS_W-1:0]          value,
	output logic                                   locked
);

	efch_pkg::efch_w1o_t st_r;
	efch_pkg::efch_w1o_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		// first write lands, later ones are dropped
		if (wr.en && (wr.mask != '0) && !st_r.locked)
		begin
			st_nxt.value  = (st_r.value & ~wr.mask) | (wr.data & wr.mask);
			st_nxt.locked = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_r <= efch_pkg::W1O_RST;
		else
			st_r <= st_nxt;
	end

	assign value  = st_r.value;
	assign locked = st_r.locked;

endmodule

// ===== tb/efch_regs_chk.sv
// Purpose: port assertions for the error function configuration header
// Assumes: single clock pclk, async active-low presetn
// Notes:   bound to efch_regs below
`timescale 1ns/1ps
module efch_regs_chk
#(
	parameter int unsigned ADDR_W = 8
)
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic              pready,
	input wire logic [31:0]       prdata,
	input wire logic              pslverr,
	input wire logic              error_event,
	input wire logic              serr_msg,
	input wire logic              system_error_signaled,
	input wire logic              irq
);
	localparam logic [ADDR_W-1:0] A_ST = ADDR_W'({efch_pkg::IDX_STATUS, 2'b00});
	localparam logic [ADDR_W-1:0] A_SC = ADDR_W'({efch_pkg::IDX_SUBCLASS, 2'b00});
	localparam logic [ADDR_W-1:0] A_BC = ADDR_W'({efch_pkg::IDX_BASE_CLASS, 2'b00});
	localparam logic [ADDR_W-1:0] A_LT = ADDR_W'({efch_pkg::IDX_LATENCY, 2'b00});
	localparam logic [ADDR_W-1:0] A_HD = ADDR_W'({efch_pkg::IDX_HEADER, 2'b00});
	logic rd;
	logic clr;
	assign rd = pready && !pwrite;
	assign clr = psel && penable && pready && pwrite && paddr == A_ST && pstrb[1] && pwdata[14];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_msg_sets_bit: assert property (serr_msg |-> system_error_signaled)
		else $error("message sent without status bit");
	a_msg_has_cause: assert property (serr_msg |-> $past(error_event))
		else $error("message without an error event");
	a_rise_by_msg: assert property ($rose(system_error_signaled) |-> serr_msg)
		else $error("status bit set without a message");
	a_bit_holds: assert property (system_error_signaled && !clr |=> system_error_signaled)
		else $error("status bit dropped without clear");
	a_w1c_clears: assert property (clr && !error_event |=> !system_error_signaled)
		else $error("write of one did not clear status bit");
	a_one_wait: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("access phase length wrong");
	a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
		else $error("read data or error outside access");
	a_status_rsvd: assert property (rd && paddr == A_ST |-> prdata[31:15] == 17'h0 && prdata[13:0] == 14'h0)
		else $error("status reserved bits not zero");
	a_base_class: assert property (rd && paddr == A_BC |-> prdata == 32'h0000_00FF)
		else $error("base class read wrong");
	a_fixed_zero: assert property (rd && (paddr == A_SC || paddr == A_LT || paddr == A_HD) |-> prdata == 32'h0 && !pslverr)
		else $error("fixed zero byte read wrong");
endmodule
bind efch_regs efch_regs_chk #(.ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.error_event(error_event), .serr_msg(serr_msg),
	.system_error_signaled(system_error_signaled), .irq(irq));

// ===== tb/error_function_config_header_tb.sv
// Purpose: register and event tests of the configuration header
// Assumes: ready in the first access cycle, bounded waits
// Notes:   addresses are index times four
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		samples_checked++; \
		if ((got) !== (ex)) \
		begin \
			err_count++; \
			$display("ERROR %s expected %h seen %h", nm, ex, got); \
		end \
	end
module error_function_config_header_tb;
	localparam logic [7:0] REV = 8'h5A; // arbitrary value
	localparam logic [7:0] ST  = efch_pkg::IDX_STATUS;
	localparam logic [7:0] IS  = efch_pkg::IDX_IRQ_STATUS;
	localparam logic [7:0] IM  = efch_pkg::IDX_IRQ_MASK;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        error_event, serr_msg, sys_err_sig, irq, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  pstrb;
	int          err_count = 0;
	int          samples_checked = 0;
	logic [7:0]  ro_idx [5] = '{efch_pkg::IDX_REVISION, efch_pkg::IDX_SUBCLASS,
		efch_pkg::IDX_BASE_CLASS, efch_pkg::IDX_LATENCY, efch_pkg::IDX_HEADER};
	logic [31:0] ro_exp [5] = '{{24'h0, REV}, 32'h0, 32'h0000_00FF, 32'h0, 32'h0};
	logic [7:0]  w1o_idx [2] = '{efch_pkg::IDX_BOARD_VENDOR, efch_pkg::IDX_BOARD_PROD};
	efch_regs #(.ADDR_W(8), .REVISION_VAL(REV)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.error_event(error_event), .serr_msg(serr_msg),
		.system_error_signaled(sys_err_sig), .irq(irq));
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task test_done();
		$display("checked %0d, errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task xfer(input logic [7:0] idx, input logic w, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_count++;
			test_done();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] s);
		xfer(idx, 1'b1, d, s);
	endtask
	task rd(input logic [7:0] idx, input logic [32:0] ex);
		xfer(idx, 1'b0, 32'h0, 4'h0);
		`CHK($sformatf("register %h", idx), ex, {e, q})
	endtask
	task ev(input logic [2:0] ex);
		@(posedge pclk);
		error_event <= 1'b1;
		@(posedge pclk);
		error_event <= 1'b0;
		@(posedge pclk);
		`CHK("message, status, irq", ex, {serr_msg, sys_err_sig, irq})
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb, error_event} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			rd(ro_idx[i], {1'b0, ro_exp[i]});
			wr(ro_idx[i], 32'hFFFF_FFFF, 4'hF);
			rd(ro_idx[i], {1'b0, ro_exp[i]});
		end
		$display("read-only test done");
		rd(ST, 33'h0);
		wr(ST, 32'hFFFF_FFFF, 4'hF);
		rd(ST, 33'h0);
		ev(3'b000);
		rd(IS, 33'h2);
		rd(ST, 33'h0);
		wr(IS, 32'h3, 4'h1);
		wr(efch_pkg::IDX_COMMAND, 32'h100, 4'h2);
		wr(IM, 32'h1, 4'h1);
		ev(3'b111);
		rd(ST, 33'h4000);
		ev(3'b111);
		wr(ST, 32'h0000_BFFF, 4'h3);
		rd(ST, 33'h4000);
		wr(ST, 32'h4000, 4'h2);
		rd(ST, 33'h0);
		`CHK("signaled", 1'b0, sys_err_sig)
		wr(IS, 32'h3, 4'h1);
		rd(IS, 33'h0);
		`CHK("irq", 1'b0, irq)
		wr(IM, 32'h0, 4'h1);
		ev(3'b110);
		$display("event test done");
		for (int i = 0; i < 2; i++)
		begin
			rd(w1o_idx[i], 33'h0);
			wr(w1o_idx[i], 32'h1234, 4'h3);
			rd(w1o_idx[i], 33'h1234);
			wr(w1o_idx[i], 32'hABCD, 4'h3);
			rd(w1o_idx[i], 33'h1234);
		end
		rd(8'h3F, {1'b1, 32'h0});
		$display("write-once test done");
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		`CHK("signaled after reset", 1'b0, sys_err_sig)
		rd(ST, 33'h0);
		rd(efch_pkg::IDX_BOARD_VENDOR, 33'h0);
		wr(efch_pkg::IDX_BOARD_VENDOR, 32'h5678, 4'h3);
		rd(efch_pkg::IDX_BOARD_VENDOR, 33'h5678);
		wr(IM, 32'h2, 4'h1);
		ev(3'b001);
		$display("reset test done");
		test_done();
	end
endmodule
